// ===== src/lls_pkg.sv
// constants for the lane link status flag bank
package lls_pkg;
   // register offsets (12-bit byte addresses)
   localparam logic [11:0] LANE5_STATE_OFS = 12'h4B5;
   localparam logic [11:0] LANE6_STATE_OFS = 12'h4B6;
   localparam logic [11:0] IRQ_STAT_OFS    = 12'h4C0;
   localparam logic [11:0] IRQ_MASK_OFS    = 12'h4C1;
   localparam logic [11:0] CNT_CLEAR_OFS   = 12'h4C2;
   // reset values and the counter saturation value
   localparam logic [7:0]  STATE_RST       = 8'h00;
   localparam logic [3:0]  IRQ_RST         = 4'h0;
   localparam logic [7:0]  CNT_RST         = 8'h00;
   localparam logic [7:0]  CNT_MAX         = 8'hFF;
   // lane status bit positions
   localparam int          DISP_BIT        = 7;
   localparam int          BADSYM_BIT      = 6;
   localparam int          CTRL_BIT        = 5;
   localparam int          DESKEW_BIT      = 4;
   localparam int          ALIGN_BIT       = 3;
   localparam int          SUM_BIT         = 2;
   localparam int          FRAME_BIT       = 1;
   localparam int          CGS_BIT         = 0;
   // interrupt status bit positions
   localparam int          IRQ_DISP_BIT    = 0;
   localparam int          IRQ_BADSYM_BIT  = 1;
   localparam int          IRQ_CTRL_BIT    = 2;
   localparam int          IRQ_LOSS_BIT    = 3;
   // counter clear register bit
   localparam int          CLEAR_BIT       = 0;
   // geometry: links paged, error kinds, counters
   localparam int          NUM_LINKS       = 2;
   localparam int          NUM_KINDS       = 3;
   localparam int          NUM_CNT         = 12;
endpackage : lls_pkg

// ===== src/lls_top.sv
// lane 5 and lane 6 link status flags, paged by link, with error counters
// register map, all registers eight bits wide
//   lane5 state   : disparity, bad symbol, stray control, deskew,
//                   alignment, checksum, frame sync, code group sync
//   lane6 state   : same layout; bit 0 is not carried and reads zero
//   irq status    : sticky event bits, a written one clears its bit
//   irq mask      : a one lets the matching status bit reach irq_o
//   counter clear : write-only strobe that zeroes all error counters
//
// timing, counted in clock edges
//   read data stand only in the cycle after the read strobe
//   a status input shows in read data two edges after it moves
//   an error pulse reaches its flag one edge after it is counted
//   a new mask reaches irq_o one edge after the write lands
//   the link page is applied at the read; software sets it first
//
// limitations
//   status flags are live copies of the lane state, not sticky
//   counters saturate at their top value and never wrap
//   one threshold serves every lane, error kind and link
//   interrupts catch a rising error flag or a falling lock only
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps

// saturating error counter with threshold flag
module lls_err_cnt (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   // control
   input  wire logic       clear_i,
   input  wire logic       event_i,
   input  wire logic [7:0] thresh_i,
   // flag
   output logic            high_o
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic       high_reg;
   logic       cnt_at_max;
   logic [7:0] cnt_inc;

   // saturate so a long error burst never wraps back below threshold
   assign cnt_at_max = (cnt_reg == lls_pkg::CNT_MAX);
   assign cnt_inc    = cnt_reg + 8'h01;
   // a clear beats an error event that lands in the same cycle
   assign cnt_next   = clear_i ? lls_pkg::CNT_RST :
                       (event_i && !cnt_at_max) ? cnt_inc : cnt_reg;

   // count and compare continuously
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_reg  <= lls_pkg::CNT_RST;
         high_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         high_reg <= (cnt_reg >= thresh_i);
      end
   end

   assign high_o = high_reg;
endmodule // lls_err_cnt

module lls_top (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   // register port
   input  wire logic [11:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [7:0]       rdata_o,
   // paging and threshold
   input  wire logic        link_page_i,
   input  wire logic [7:0]  error_count_threshold_i,
   // lane 5 status per link
   input  wire logic [1:0]  lane5_align_seq_ok_i,
   input  wire logic [1:0]  lane5_sum_check_ok_i,
   input  wire logic [1:0]  lane5_frame_locked_i,
   input  wire logic [1:0]  lane5_codegroup_locked_i,
   input  wire logic [1:0]  lane5_deskew_done_i,
   // lane 6 status per link
   input  wire logic [1:0]  lane6_align_seq_ok_i,
   input  wire logic [1:0]  lane6_sum_check_ok_i,
   input  wire logic [1:0]  lane6_frame_locked_i,
   input  wire logic [1:0]  lane6_deskew_done_i,
   // error event pulses per link
   input  wire logic [1:0]  lane5_disparity_err_i,
   input  wire logic [1:0]  lane5_badsymbol_err_i,
   input  wire logic [1:0]  lane5_stray_ctrl_err_i,
   input  wire logic [1:0]  lane6_disparity_err_i,
   input  wire logic [1:0]  lane6_badsymbol_err_i,
   input  wire logic [1:0]  lane6_stray_ctrl_err_i,
   // interrupt
   output logic             irq_o
);
   // captured lane status, index is the link
   logic [1:0] l5_align_reg;
   logic [1:0] l5_sum_reg;
   logic [1:0] l5_frame_reg;
   logic [1:0] l5_cgs_reg;
   logic [1:0] l5_deskew_reg;
   logic [1:0] l6_align_reg;
   logic [1:0] l6_sum_reg;
   logic [1:0] l6_frame_reg;
   logic [1:0] l6_deskew_reg;

   // interrupt and read path state
   logic [3:0]  irq_stat_reg;
   logic [3:0]  irq_stat_next;
   logic [3:0]  irq_mask_reg;
   logic [11:0] high_dly_reg;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic        irq_reg;

   // counter wiring: index = lane*6 + kind*2 + link
   logic [11:0] err_evt;
   logic [11:0] err_high;
   logic [11:0] err_rise;
   logic        cnt_clear;

   // address decode
   // all twelve bits are compared, so no register shows up at an alias
   logic hit_l5;
   logic hit_l6;
   logic hit_stat;
   logic hit_mask;
   logic hit_clear;

   assign hit_l5    = (addr_i == lls_pkg::LANE5_STATE_OFS);
   assign hit_l6    = (addr_i == lls_pkg::LANE6_STATE_OFS);
   assign hit_stat  = (addr_i == lls_pkg::IRQ_STAT_OFS);
   assign hit_mask  = (addr_i == lls_pkg::IRQ_MASK_OFS);
   assign hit_clear = (addr_i == lls_pkg::CNT_CLEAR_OFS);

   // clear strobe is a self-clearing write, no storage needed
   assign cnt_clear = wr_i && hit_clear && wdata_i[lls_pkg::CLEAR_BIT];

   // error event vector, lane 5 in the low half
   // this order must match the indexes used by the paged views below
   assign err_evt = {lane6_stray_ctrl_err_i,
                     lane6_badsymbol_err_i,
                     lane6_disparity_err_i,
                     lane5_stray_ctrl_err_i,
                     lane5_badsymbol_err_i,
                     lane5_disparity_err_i};

   // one counter per lane, kind and link
   // twelve small counters keep lanes and links apart at a modest area cost
   genvar g;
   generate
      for (g = 0; g < lls_pkg::NUM_CNT; g++) begin : g_cnt
         lls_err_cnt u_cnt (
            .mclk_i   (mclk_i),
            .rst_i    (rst_i),
            .clear_i  (cnt_clear),
            .event_i  (err_evt[g]),
            .thresh_i (error_count_threshold_i),
            .high_o   (err_high[g])
         );
      end
   endgenerate

   // capture lane status; all flags start at zero
   // one flop per input: the lane logic shares this clock, so no synchroniser
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         l5_align_reg  <= 2'h0;
         l5_sum_reg    <= 2'h0;
         l5_frame_reg  <= 2'h0;
         l5_cgs_reg    <= 2'h0;
         l5_deskew_reg <= 2'h0;
         l6_align_reg  <= 2'h0;
         l6_sum_reg    <= 2'h0;
         l6_frame_reg  <= 2'h0;
         l6_deskew_reg <= 2'h0;
      end else begin
         l5_align_reg  <= lane5_align_seq_ok_i;
         l5_sum_reg    <= lane5_sum_check_ok_i;
         l5_frame_reg  <= lane5_frame_locked_i;
         l5_cgs_reg    <= lane5_codegroup_locked_i;
         l5_deskew_reg <= lane5_deskew_done_i;
         l6_align_reg  <= lane6_align_seq_ok_i;
         l6_sum_reg    <= lane6_sum_check_ok_i;
         l6_frame_reg  <= lane6_frame_locked_i;
         l6_deskew_reg <= lane6_deskew_done_i;
      end
   end

   // paged views of the two status registers
   logic [7:0] lane5_link_state;
   logic [7:0] lane6_link_state;
   logic       pg;

   // software must set the page first; a read shows whatever is paged now
   assign pg = link_page_i;

   // lane5 upper bits carry its own error flags and deskew
   assign lane5_link_state = {err_high[0 + pg],   // disparity
                              err_high[2 + pg],   // bad symbol
                              err_high[4 + pg],   // stray control
                              l5_deskew_reg[pg],
                              l5_align_reg[pg],
                              l5_sum_reg[pg],
                              l5_frame_reg[pg],
                              l5_cgs_reg[pg]};

   // code group sync of lane 6 is not carried here and reads zero
   assign lane6_link_state = {err_high[6 + pg],
                              err_high[8 + pg],
                              err_high[10 + pg],
                              l6_deskew_reg[pg],
                              l6_align_reg[pg],
                              l6_sum_reg[pg],
                              l6_frame_reg[pg],
                              1'b0};

   // read mux; unmapped addresses read zero, status regs ignore writes
   // read data are zero outside the read cycle, so an or of read buses stays clean
   assign rdata_next = !rd_i     ? 8'h00 :
                       hit_l5    ? lane5_link_state :
                       hit_l6    ? lane6_link_state :
                       hit_stat  ? {4'h0, irq_stat_reg} :
                       hit_mask  ? {4'h0, irq_mask_reg} :
                       8'h00;

   // rising threshold flags and lost lock are the interrupt events
   logic [3:0] irq_evt;
   logic [1:0] loss_l5;
   logic [1:0] loss_l6;
   logic [1:0] l5_frame_dly_reg;
   logic [1:0] l5_cgs_dly_reg;
   logic [1:0] l6_frame_dly_reg;

   // a link drop clears every stage together, giving one loss event per drop
   assign err_rise = err_high & ~high_dly_reg;
   assign loss_l5  = (l5_frame_dly_reg & ~l5_frame_reg) | (l5_cgs_dly_reg & ~l5_cgs_reg);
   assign loss_l6  = l6_frame_dly_reg & ~l6_frame_reg;

   assign irq_evt[lls_pkg::IRQ_DISP_BIT]   = |{err_rise[7:6], err_rise[1:0]};
   assign irq_evt[lls_pkg::IRQ_BADSYM_BIT] = |{err_rise[9:8], err_rise[3:2]};
   assign irq_evt[lls_pkg::IRQ_CTRL_BIT]   = |{err_rise[11:10], err_rise[5:4]};
   assign irq_evt[lls_pkg::IRQ_LOSS_BIT]   = |{loss_l5, loss_l6};

   // write one to clear; a new event in the same cycle wins
   logic       stat_wr;
   logic       mask_wr;
   logic [3:0] stat_clr;
   logic       irq_next;

   // write decodes shared by the status and mask registers
   assign stat_wr       = wr_i && hit_stat;
   assign mask_wr       = wr_i && hit_mask;
   assign stat_clr      = stat_wr ? wdata_i[3:0] : 4'h0;
   assign irq_stat_next = (irq_stat_reg & ~stat_clr) | irq_evt;

   // irq rises at the edge that sets status; a new mask counts one edge later
   assign irq_next      = |(irq_stat_next & irq_mask_reg);

   // interrupt, mask and read data registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_stat_reg     <= lls_pkg::IRQ_RST;
         irq_mask_reg     <= lls_pkg::IRQ_RST;
         high_dly_reg     <= 12'h000;
         l5_frame_dly_reg <= 2'h0;
         l5_cgs_dly_reg   <= 2'h0;
         l6_frame_dly_reg <= 2'h0;
         rdata_reg        <= lls_pkg::STATE_RST;
         irq_reg          <= 1'b0;
      end else begin
         irq_stat_reg     <= irq_stat_next;
         if (mask_wr) begin
            irq_mask_reg <= wdata_i[3:0];
         end
         high_dly_reg     <= err_high;
         l5_frame_dly_reg <= l5_frame_reg;
         l5_cgs_dly_reg   <= l5_cgs_reg;
         l6_frame_dly_reg <= l6_frame_reg;
         rdata_reg        <= rdata_next;
         irq_reg          <= irq_next;
      end
   end

   // outputs come straight from flops
   assign rdata_o = rdata_reg;
   assign irq_o   = irq_reg;
endmodule // lls_top

// ===== tb/lls_monitor.sv
// checker on the lane link status register port
`timescale 1ns/10ps
module lls_monitor (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // register port and paging
   input  wire logic [11:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  rdata_o,
   input  wire logic        link_page_i,
   // lane flags and interrupt
   input  wire logic [1:0]  lane5_frame_locked_i,
   input  wire logic [1:0]  lane5_codegroup_locked_i,
   input  wire logic        irq_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // read decodes; the stable guard covers the one input flop ahead of the read mux
   wire logic rd5 = rd_i && addr_i == lls_pkg::LANE5_STATE_OFS;
   wire logic rd6 = rd_i && addr_i == lls_pkg::LANE6_STATE_OFS;
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (rd_i && addr_i == 12'h300 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_clear_reads_zero: assert property (rd_i && addr_i == lls_pkg::CNT_CLEAR_OFS |=> rdata_o == 8'h00)
      else $error("counter clear register not reading zero");
   a_lane6_bit0: assert property (rd6 |=> !rdata_o[0])
      else $error("lane6 bit0 set");
   a_frame5_bit: assert property (rd5 && !$past(rst_i) && $stable(lane5_frame_locked_i) |=>
      rdata_o[1] == $past(lane5_frame_locked_i[link_page_i])) else $error("lane5 frame bit wrong");
   a_lane5_codegroup_locked_bit: assert property (rd5 && !$past(rst_i) && $stable(lane5_codegroup_locked_i) |=>
      rdata_o[0] == $past(lane5_codegroup_locked_i[link_page_i])) else $error("lane5 code group bit wrong");
   a_lane5_ro: assert property (wr_i && addr_i == lls_pkg::LANE5_STATE_OFS ##2 rd5 |=> rdata_o[7:5] == 3'h0 ||
      rdata_o[7:5] != $past(wdata_i[7:5], 3)) else $error("lane5 register took write data");
   a_irq_masked: assert property (wr_i && addr_i == lls_pkg::IRQ_MASK_OFS && wdata_i == 8'h00 ##1 !wr_i |=> !irq_o)
      else $error("interrupt high with mask cleared");
endmodule // lls_monitor

bind lls_top lls_monitor u_lls_monitor (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_page_i(link_page_i), .irq_o(irq_o),
   .lane5_frame_locked_i(lane5_frame_locked_i), .lane5_codegroup_locked_i(lane5_codegroup_locked_i));

// ===== tb/lls_tx_model.sv
// behavioural far-end transmitter: lane bring-up stages and error pulses
`timescale 1ns/10ps
module lls_tx_model (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // bench commands
   input  wire logic [1:0]  link_up_i,
   input  wire logic [11:0] err_req_i,
   // lane side
   output logic [1:0]       cgs_o,
   output logic [1:0]       frm_o,
   output logic [1:0]       ils_o,
   output logic [1:0]       cks_o,
   output logic [1:0]       dsk_o,
   output logic [11:0]      err_o
);
   logic [2:0] step_reg [2];
   // stages come up in order; dropping a link restarts it, so sync loss is a real fall
   always_ff @(posedge mclk_i) begin
      err_o <= rst_i ? 12'h000 : err_req_i;
      for (int l = 0; l < 2; l++) begin
         if (rst_i || !link_up_i[l]) step_reg[l] <= 3'h0;
         else if (step_reg[l] != 3'h5) step_reg[l] <= step_reg[l] + 3'h1;
      end
   end
   // stage thermometer per link
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         cgs_o[l] = step_reg[l] >= 3'h1;
         frm_o[l] = step_reg[l] >= 3'h2;
         ils_o[l] = step_reg[l] >= 3'h3;
         cks_o[l] = step_reg[l] >= 3'h4;
         dsk_o[l] = step_reg[l] >= 3'h5;
      end
   end
endmodule // lls_tx_model

// ===== tb/lls_top_tb_top.sv
// testbench for the lane link status flag bank
`timescale 1ns/10ps
module lls_top_tb_top;
   logic             mclk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic [11:0]      addr_i = 12'h000;
   logic [7:0]       wdata_i = 8'h00;
   logic             wr_i = 1'b0;
   logic             rd_i = 1'b0;
   logic             page = 1'b0;
   logic [1:0]       link_up = 2'h0;
   logic [11:0]      err_req = 12'h000;
   logic [7:0]       e6;
   logic [7:0]       thr = 8'h03;
   wire logic [7:0]  rdata_o;
   wire logic        irq_o;
   wire logic [1:0]  cgs, frm, ils, cks, dsk;
   wire logic [11:0] err;
   int               err_total = 0;
   int               total_checks = 0;
   int               cyc = 0;
   always #4 mclk_i = ~mclk_i;
   lls_tx_model u_lls_tx_model (.mclk_i(mclk_i), .rst_i(rst_i), .link_up_i(link_up), .err_req_i(err_req),
      .cgs_o(cgs), .frm_o(frm), .ils_o(ils), .cks_o(cks), .dsk_o(dsk), .err_o(err));
   lls_top u_lls_top (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .link_page_i(page), .error_count_threshold_i(thr),
      .lane5_align_seq_ok_i(ils), .lane5_sum_check_ok_i(cks), .lane5_frame_locked_i(frm),
      .lane5_codegroup_locked_i(cgs), .lane5_deskew_done_i(dsk), .lane6_align_seq_ok_i(ils),
      .lane6_sum_check_ok_i(cks), .lane6_frame_locked_i(frm), .lane6_deskew_done_i(dsk),
      .lane5_disparity_err_i(err[1:0]), .lane5_badsymbol_err_i(err[3:2]), .lane5_stray_ctrl_err_i(err[5:4]),
      .lane6_disparity_err_i(err[7:6]), .lane6_badsymbol_err_i(err[9:8]), .lane6_stray_ctrl_err_i(err[11:10]),
      .irq_o(irq_o));
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk8($sformatf("reg %h", a), e, rdata_o);
   endtask
   // n error pulses on one lane and link, then let the flag pipe settle
   task automatic pulse(input int i, input int n);
      @(posedge mclk_i);
      err_req[i] <= 1'b1;
      repeat (n) @(posedge mclk_i);
      err_req[i] <= 1'b0;
      repeat (3) @(posedge mclk_i);
   endtask
   task automatic summarize;
      if (err_total == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // hang guard, well above the roughly 126 cycles the run needs
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(lls_pkg::LANE5_STATE_OFS, 8'h00);
      rd(lls_pkg::LANE6_STATE_OFS, 8'h00);
      wr(lls_pkg::LANE5_STATE_OFS, 8'hFF);
      rd(lls_pkg::LANE5_STATE_OFS, 8'h00);
      rd(12'h300, 8'h00);
      link_up <= 2'h1;
      // mid bring-up: alignment done, checksum and deskew not yet
      repeat (3) @(posedge mclk_i);
      rd(lls_pkg::LANE5_STATE_OFS, 8'h0B);
      repeat (10) @(posedge mclk_i);
      rd(lls_pkg::LANE5_STATE_OFS, 8'h1F);
      rd(lls_pkg::LANE6_STATE_OFS, 8'h1E);
      page <= 1'b1;
      rd(lls_pkg::LANE5_STATE_OFS, 8'h00);
      link_up <= 2'h3;
      repeat (3) @(posedge mclk_i);
      rd(lls_pkg::LANE6_STATE_OFS, 8'h0A);
      page <= 1'b0;
      // two errors stay below the threshold of three, the third reaches it
      e6 = 8'h1E;
      for (int k = 0; k < 3; k++) begin
         pulse(6 + 2 * k, 2);
         rd(lls_pkg::LANE6_STATE_OFS, e6);
         pulse(6 + 2 * k, 1);
         e6 = e6 | (8'h80 >> k);
         rd(lls_pkg::LANE6_STATE_OFS, e6);
      end
      pulse(0, 3);
      rd(lls_pkg::LANE5_STATE_OFS, 8'h9F);
      // a raised threshold drops the flag at the same count
      thr <= 8'h04;
      rd(lls_pkg::LANE5_STATE_OFS, 8'h1F);
      thr <= 8'h03;
      wr(lls_pkg::CNT_CLEAR_OFS, 8'h01);
      rd(lls_pkg::LANE6_STATE_OFS, 8'h1E);
      rd(lls_pkg::CNT_CLEAR_OFS, 8'h00);
      chk8("irq masked", 8'h00, {7'h00, irq_o});
      wr(lls_pkg::IRQ_MASK_OFS, 8'h0F);
      @(posedge mclk_i);
      #1;
      chk8("irq enabled", 8'h01, {7'h00, irq_o});
      rd(lls_pkg::IRQ_STAT_OFS, 8'h07);
      link_up <= 2'h0;
      repeat (4) @(posedge mclk_i);
      rd(lls_pkg::IRQ_STAT_OFS, 8'h0F);
      wr(lls_pkg::IRQ_MASK_OFS, 8'h00);
      @(posedge mclk_i);
      #1;
      chk8("irq off", 8'h00, {7'h00, irq_o});
      wr(lls_pkg::IRQ_STAT_OFS, 8'h0F);
      rd(lls_pkg::IRQ_STAT_OFS, 8'h00);
      summarize();
   end
endmodule // lls_top_tb_top
